// *** verilog/crs_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crs_regs.svh"
module crs_core #(
	parameter int unsigned STAB_CYC = `CRS_STAB_CYC
) (
	input wire logic clk, // 50 MHz
	input wire logic reset, // async, high
	input wire logic awvalid, // axi write address
	output logic awready, // axi
	input wire logic [7:0] awaddr, // byte address
	input wire logic wvalid, // axi write data
	output logic wready, // axi
	input wire logic [31:0] wdata, // data
	input wire logic [3:0] wstrb, // byte lanes
	output logic bvalid, // write response
	input wire logic bready, // axi
	output logic [1:0] bresp, // okay or slverr
	input wire logic arvalid, // axi read address
	output logic arready, // axi
	input wire logic [7:0] araddr, // byte address
	output logic rvalid, // read data valid
	input wire logic rready, // axi
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // okay or slverr
	input wire logic cmdValid, // op offered
	output logic cmdReady, // core running
	input wire crs_pkg::crs_cmd_t cmd, // op and operand
	output logic vecRd, // vector byte wanted
	output logic [15:0] vecAddr, // vector address
	input wire logic vecValid, // vector byte present
	input wire logic [7:0] vecData, // vector byte
	output logic [15:0] stackAddr, // stack-relative address
	output logic [7:0] pushData, // byte being pushed
	input wire logic [3:0] irqPend, // requests, bit 0 highest
	output logic irqReq, // take an interrupt
	output logic [1:0] irqSel, // which one
	output logic coreRun, // core clock enabled
	output logic illegalRst // illegal-opcode reset pulse
);
	logic [7:0] accumulator_r;
	logic [15:0] indexPair_r;
	logic [15:0] stackPointer_r;
	logic [15:0] programCounter_r;
	crs_pkg::crs_flags_t flags_r;
	logic haltEn_r;
	crs_pkg::crs_state_t state_r;
	crs_pkg::crs_state_t state_nxt;
	logic [12:0] stabCnt_r;
	logic awHeld_r, wHeld_r;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic go, softRst, wrFire;
	logic [2:0] wrIdx, rdIdx;
	logic [7:0] opd, aluRes, flagByte;
	logic cin, aluC, aluV, updNZ, updV, updC, updH, daaLo, daaHi;
	logic [4:0] half;
	logic [8:0] sum, dif;

	// register index from byte address, 7 means unmapped
	function automatic logic [2:0] regIdx(input logic [7:0] a);
		case (a)
			`CRS_ACC_OFS: regIdx = 3'h0;
			`CRS_IDX_OFS: regIdx = 3'h1;
			`CRS_STK_OFS: regIdx = 3'h2;
			`CRS_PGM_OFS: regIdx = 3'h3;
			`CRS_FLG_OFS: regIdx = 3'h4;
			`CRS_CTL_OFS: regIdx = 3'h5;
			`CRS_STA_OFS: regIdx = 3'h6;
			default: regIdx = 3'h7;
		endcase
	endfunction : regIdx

	// lowest index pending wins
	function automatic logic [1:0] topIrq(input logic [3:0] p);
		topIrq = 2'h0;
		for (int k = `CRS_IRQ_N - 1; k >= 0; k--) begin
			if (p[k]) begin
				topIrq = 2'(k);
			end
		end
	endfunction : topIrq

	// merge byte lanes into a 16-bit register
	function automatic logic [15:0] mrg(input logic [15:0] o, input logic [31:0] d, input logic [3:0] s);
		mrg = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction : mrg

	assign go = cmdValid && cmdReady;
	assign softRst = go && cmd.op == crs_pkg::OP_HALT && !haltEn_r;
	assign wrFire = awHeld_r && wHeld_r && !bvalid && !go;
	assign wrIdx = regIdx(awAddr_r);
	assign rdIdx = regIdx(araddr);

	// flags packed for reads, fixed ones in six and five
	always_comb begin
		flagByte = 8'h00;
		flagByte[`CRS_V_BIT] = flags_r.v;
		flagByte[`CRS_ONE6_BIT] = 1'b1;
		flagByte[`CRS_ONE5_BIT] = 1'b1;
		flagByte[`CRS_H_BIT] = flags_r.h;
		flagByte[`CRS_I_BIT] = flags_r.i;
		flagByte[`CRS_N_BIT] = flags_r.n;
		flagByte[`CRS_Z_BIT] = flags_r.z;
		flagByte[`CRS_C_BIT] = flags_r.c;
	end

	// arithmetic unit on the accumulator
	always_comb begin
		opd = cmd.data[7:0];
		cin = (cmd.op == crs_pkg::OP_ADC) ? flags_r.c : 1'b0;
		half = {1'b0, accumulator_r[3:0]} + {1'b0, opd[3:0]} + {4'h0, cin};
		sum = {1'b0, accumulator_r} + {1'b0, opd} + {8'h00, cin};
		dif = {1'b0, accumulator_r} - {1'b0, opd};
		daaLo = flags_r.h || accumulator_r[3:0] > 4'h9;
		daaHi = flags_r.c || accumulator_r > 8'h99;
		aluRes = accumulator_r;
		aluC = flags_r.c;
		aluV = flags_r.v;
		updNZ = 1'b1;
		updV = 1'b1;
		updC = 1'b0;
		updH = 1'b0;
		case (cmd.op)
			crs_pkg::OP_ADD, crs_pkg::OP_ADC: begin
				aluRes = sum[7:0];
				aluC = sum[8];
				aluV = (accumulator_r[7] == opd[7]) && (sum[7] != accumulator_r[7]);
				updC = 1'b1;
				updH = 1'b1;
			end
			crs_pkg::OP_SUB: begin
				aluRes = dif[7:0];
				aluC = dif[8];
				aluV = (accumulator_r[7] != opd[7]) && (dif[7] != accumulator_r[7]);
				updC = 1'b1;
			end
			crs_pkg::OP_AND: begin
				aluRes = accumulator_r & opd;
				aluV = 1'b0;
			end
			crs_pkg::OP_LSL: begin
				aluRes = {accumulator_r[6:0], 1'b0};
				aluC = accumulator_r[7];
				aluV = accumulator_r[7] ^ accumulator_r[6];
				updC = 1'b1;
			end
			crs_pkg::OP_LOAD_ACC: begin
				aluRes = opd;
				aluV = 1'b0;
			end
			crs_pkg::OP_DECIMAL_ADJUST: begin
				aluRes = accumulator_r + {daaHi ? 4'h6 : 4'h0, daaLo ? 4'h6 : 4'h0};
				aluC = daaHi;
				updC = 1'b1;
				updV = 1'b0;
			end
			default: begin
				updNZ = 1'b0;
				updV = 1'b0;
			end
		endcase
	end

	// accumulator
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			accumulator_r <= 8'h00;
		end else if (go && updNZ) begin
			accumulator_r <= aluRes;
		end else if (wrFire && wrIdx == 3'h0 && wStrb_r[0]) begin
			accumulator_r <= wData_r[7:0];
		end
	end

	// index pair, high byte also moves alone by its own pull op
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			indexPair_r <= 16'h0000;
		end else if (go && cmd.op == crs_pkg::OP_LOAD_INDEX) begin
			indexPair_r <= cmd.data;
		end else if (go && cmd.op == crs_pkg::OP_PULL_INDEX_HIGH) begin
			indexPair_r[15:8] <= cmd.data[7:0];
		end else if (wrFire && wrIdx == 3'h1) begin
			indexPair_r <= mrg(indexPair_r, wData_r, wStrb_r);
		end
	end

	// stack pointer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stackPointer_r <= `CRS_STK_RST;
		end else if (softRst) begin
			stackPointer_r <= `CRS_STK_RST;
		end else if (go) begin
			case (cmd.op)
				crs_pkg::OP_PUSH, crs_pkg::OP_PUSH_INDEX_HIGH: stackPointer_r <= stackPointer_r - 16'h0001;
				crs_pkg::OP_PULL, crs_pkg::OP_PULL_INDEX_HIGH,
				crs_pkg::OP_INTERRUPT_RETURN: stackPointer_r <= stackPointer_r + 16'h0001;
				crs_pkg::OP_STACK_LOW_RESET: stackPointer_r[7:0] <= `CRS_STK_LOW;
				default: stackPointer_r <= stackPointer_r;
			endcase
		end else if (wrFire && wrIdx == 3'h2) begin
			stackPointer_r <= mrg(stackPointer_r, wData_r, wStrb_r);
		end
	end

	// stack-relative address and push byte
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stackAddr <= 16'h0000;
			pushData <= 8'h00;
		end else if (go) begin
			if (cmd.op == crs_pkg::OP_STACK_REL8) begin
				stackAddr <= stackPointer_r + {8'h00, cmd.data[7:0]};
			end
			if (cmd.op == crs_pkg::OP_STACK_REL16) begin
				stackAddr <= stackPointer_r + cmd.data;
			end
			if (cmd.op == crs_pkg::OP_PUSH) begin
				pushData <= accumulator_r;
			end
			if (cmd.op == crs_pkg::OP_PUSH_INDEX_HIGH) begin
				pushData <= indexPair_r[15:8];
			end
		end
	end

	// program counter, vector bytes high first
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			programCounter_r <= 16'h0000;
		end else if (state_r == crs_pkg::ST_VHI && vecValid) begin
			programCounter_r[15:8] <= vecData;
		end else if (state_r == crs_pkg::ST_VLO && vecValid) begin
			programCounter_r[7:0] <= vecData;
		end else if (go && cmd.op == crs_pkg::OP_FETCH) begin
			programCounter_r <= programCounter_r + 16'h0001;
		end else if (go && (cmd.op == crs_pkg::OP_JUMP || cmd.op == crs_pkg::OP_INT_ENTER)) begin
			programCounter_r <= cmd.data;
		end else if (wrFire && wrIdx == 3'h3) begin
			programCounter_r <= mrg(programCounter_r, wData_r, wStrb_r);
		end
	end

	// condition flags; software bus writes never touch the mask
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flags_r <= '{v: 1'b0, h: 1'b0, i: 1'b1, n: 1'b0, z: 1'b0, c: 1'b0};
		end else if (softRst) begin
			flags_r.i <= 1'b1;
		end else if (go) begin
			if (updNZ) begin
				flags_r.n <= aluRes[7];
				flags_r.z <= aluRes == 8'h00;
			end
			if (updV) begin
				flags_r.v <= aluV;
			end
			if (updC) begin
				flags_r.c <= aluC;
			end
			if (updH) begin
				flags_r.h <= half[4];
			end
			case (cmd.op)
				crs_pkg::OP_INT_ENTER: flags_r.i <= 1'b1;
				crs_pkg::OP_MASK_CLEAR, crs_pkg::OP_WAIT, crs_pkg::OP_HALT: flags_r.i <= 1'b0;
				crs_pkg::OP_INTERRUPT_RETURN: begin
					flags_r.v <= cmd.data[`CRS_V_BIT];
					flags_r.h <= cmd.data[`CRS_H_BIT];
					flags_r.i <= cmd.data[`CRS_I_BIT];
					flags_r.n <= cmd.data[`CRS_N_BIT];
					flags_r.z <= cmd.data[`CRS_Z_BIT];
					flags_r.c <= cmd.data[`CRS_C_BIT];
				end
				default: flags_r.i <= flags_r.i;
			endcase
		end else if (wrFire && wrIdx == 3'h4 && wStrb_r[0]) begin
			flags_r.v <= wData_r[`CRS_V_BIT];
			flags_r.h <= wData_r[`CRS_H_BIT];
			flags_r.n <= wData_r[`CRS_N_BIT];
			flags_r.z <= wData_r[`CRS_Z_BIT];
			flags_r.c <= wData_r[`CRS_C_BIT];
		end
	end

	// halt enable option
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			haltEn_r <= `CRS_HALTEN_RST;
		end else if (wrFire && wrIdx == 3'h5 && wStrb_r[0]) begin
			haltEn_r <= wData_r[`CRS_HALTEN_BIT];
		end
	end

	// sequencing: vector fetch, run, wait, halt, stabilise
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			crs_pkg::ST_VHI: if (vecValid) state_nxt = crs_pkg::ST_VLO;
			crs_pkg::ST_VLO: if (vecValid) state_nxt = crs_pkg::ST_RUN;
			crs_pkg::ST_RUN: begin
				if (softRst) begin
					state_nxt = crs_pkg::ST_VHI;
				end else if (go && cmd.op == crs_pkg::OP_HALT) begin
					state_nxt = crs_pkg::ST_HALT;
				end else if (go && cmd.op == crs_pkg::OP_WAIT) begin
					state_nxt = crs_pkg::ST_WAIT;
				end
			end
			crs_pkg::ST_WAIT: if (|irqPend) state_nxt = crs_pkg::ST_RUN;
			crs_pkg::ST_HALT: if (|irqPend) state_nxt = crs_pkg::ST_STAB;
			crs_pkg::ST_STAB: if (stabCnt_r == 13'h0000) state_nxt = crs_pkg::ST_RUN;
			default: state_nxt = crs_pkg::ST_VHI;
		endcase
	end

	// state register and run-side outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= crs_pkg::ST_VHI;
			cmdReady <= 1'b0;
			coreRun <= 1'b0;
			vecRd <= 1'b1;
			vecAddr <= `CRS_VEC_HI;
			illegalRst <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cmdReady <= state_nxt == crs_pkg::ST_RUN;
			coreRun <= state_nxt != crs_pkg::ST_WAIT && state_nxt != crs_pkg::ST_HALT && state_nxt != crs_pkg::ST_STAB;
			vecRd <= state_nxt == crs_pkg::ST_VHI || state_nxt == crs_pkg::ST_VLO;
			vecAddr <= (state_nxt == crs_pkg::ST_VLO) ? `CRS_VEC_LO : `CRS_VEC_HI;
			illegalRst <= softRst;
		end
	end

	// oscillator stabilisation counter
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stabCnt_r <= 13'h0000;
		end else if (state_r == crs_pkg::ST_HALT) begin
			stabCnt_r <= 13'(STAB_CYC - 1);
		end else if (state_r == crs_pkg::ST_STAB && stabCnt_r != 13'h0000) begin
			stabCnt_r <= stabCnt_r - 13'h0001;
		end
	end

	// interrupt request to the sequencer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irqReq <= 1'b0;
			irqSel <= 2'h0;
		end else begin
			irqReq <= state_r == crs_pkg::ST_RUN && !flags_r.i && |irqPend;
			irqSel <= topIrq(irqPend);
		end
	end

	// axi write channels, one write in flight
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			awready <= 1'b1;
			wready <= 1'b1;
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `CRS_RESP_OK;
		end else begin
			if (awvalid && awready) begin
				awAddr_r <= awaddr;
				awHeld_r <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wData_r <= wdata;
				wStrb_r <= wstrb;
				wHeld_r <= 1'b1;
				wready <= 1'b0;
			end
			if (wrFire) begin
				bvalid <= 1'b1;
				bresp <= (wrIdx == 3'h7) ? `CRS_RESP_ERR : `CRS_RESP_OK;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// axi read channels
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `CRS_RESP_OK;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= (rdIdx == 3'h7) ? `CRS_RESP_ERR : `CRS_RESP_OK;
			case (rdIdx)
				3'h0: rdata <= {24'h000000, accumulator_r};
				3'h1: rdata <= {16'h0000, indexPair_r};
				3'h2: rdata <= {16'h0000, stackPointer_r};
				3'h3: rdata <= {16'h0000, programCounter_r};
				3'h4: rdata <= {24'h000000, flagByte};
				3'h5: rdata <= {31'h0000_0000, haltEn_r};
				3'h6: rdata <= {25'h000_0000, coreRun, state_r};
				default: rdata <= 32'h0000_0000;
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	default clocking dc @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_haltGo; go && cmd.op == crs_pkg::OP_HALT && haltEn_r; endsequence
	sequence s_stalled; !coreRun [*8]; endsequence
	property p_stkLow; go && cmd.op == crs_pkg::OP_STACK_LOW_RESET |=>
		stackPointer_r[7:0] == 8'hFF && stackPointer_r[15:8] == $past(stackPointer_r[15:8]); endproperty
	a_stkLow: assert property (p_stkLow) else $error("stack low reset wrong");
	property p_push; go && cmd.op == crs_pkg::OP_PUSH |=> stackPointer_r == $past(stackPointer_r) - 16'h0001; endproperty
	a_push: assert property (p_push) else $error("push did not decrement");
	property p_ones; arvalid && arready && rdIdx == 3'h4 |=> rdata[6:5] == 2'h3; endproperty
	a_ones: assert property (p_ones) else $error("fixed flag bits not one");
	property p_maskClr; $fell(flags_r.i) |-> $past(go) && ($past(cmd.op) == crs_pkg::OP_MASK_CLEAR
		|| $past(cmd.op) == crs_pkg::OP_WAIT || $past(cmd.op) == crs_pkg::OP_HALT
		|| $past(cmd.op) == crs_pkg::OP_INTERRUPT_RETURN); endproperty
	a_maskClr: assert property (p_maskClr) else $error("mask cleared without cause");
	property p_intEnter; go && cmd.op == crs_pkg::OP_INT_ENTER |=> flags_r.i && programCounter_r == $past(cmd.data); endproperty
	a_intEnter: assert property (p_intEnter) else $error("interrupt entry wrong");
	property p_wait; go && cmd.op == crs_pkg::OP_WAIT |=> !flags_r.i && !cmdReady ##1 !coreRun; endproperty
	a_wait: assert property (p_wait) else $error("wait did not stop core");
	property p_halt; s_haltGo |=> !flags_r.i ##1 s_stalled; endproperty
	a_halt: assert property (p_halt) else $error("halt restarted too early");
	property p_illegal; go && cmd.op == crs_pkg::OP_HALT && !haltEn_r |=>
		illegalRst && flags_r.i && stackPointer_r == 16'h00FF && state_r == crs_pkg::ST_VHI; endproperty
	a_illegal: assert property (p_illegal) else $error("illegal halt not reset");
	property p_vecHi; state_r == crs_pkg::ST_VHI && vecValid |=> programCounter_r[15:8] == $past(vecData)
		&& vecAddr == 16'hFFFF; endproperty
	a_vecHi: assert property (p_vecHi) else $error("vector high byte wrong");
	property p_prio; irqPend[0] |=> irqSel == 2'h0; endproperty
	a_prio: assert property (p_prio) else $error("priority not honoured");
	property p_zero; go && updNZ && aluRes == 8'h00 |=> flags_r.z && !flags_r.n; endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule : crs_core
`default_nettype wire

// *** verilog/crs_regs.svh ***
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH
`define CRS_ACC_OFS 8'h00
`define CRS_IDX_OFS 8'h04
`define CRS_STK_OFS 8'h08
`define CRS_PGM_OFS 8'h0C
`define CRS_FLG_OFS 8'h10
`define CRS_CTL_OFS 8'h14
`define CRS_STA_OFS 8'h18
`define CRS_STK_RST 16'h00FF
`define CRS_STK_LOW 8'hFF
`define CRS_VEC_HI 16'hFFFE
`define CRS_VEC_LO 16'hFFFF
`define CRS_V_BIT 7
`define CRS_ONE6_BIT 6
`define CRS_ONE5_BIT 5
`define CRS_H_BIT 4
`define CRS_I_BIT 3
`define CRS_N_BIT 2
`define CRS_Z_BIT 1
`define CRS_C_BIT 0
`define CRS_HALTEN_BIT 0
`define CRS_HALTEN_RST 1'b1
`define CRS_STAB_CYC 4096
`define CRS_IRQ_N 4
`define CRS_RESP_OK 2'h0
`define CRS_RESP_ERR 2'h2
`endif

// *** verilog/crs_pkg.sv ***
`default_nettype none
package crs_pkg;
	typedef enum logic [4:0] {
		OP_NOP, OP_FETCH, OP_JUMP, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_LSL, OP_LOAD_ACC,
		OP_DECIMAL_ADJUST, OP_LOAD_INDEX, OP_PUSH, OP_PULL, OP_STACK_LOW_RESET, OP_MASK_CLEAR,
		OP_INTERRUPT_RETURN, OP_INT_ENTER, OP_WAIT, OP_HALT, OP_STACK_REL8, OP_STACK_REL16,
		OP_PUSH_INDEX_HIGH, OP_PULL_INDEX_HIGH
	} crs_op_t;
	typedef enum logic [5:0] {
		ST_VHI = 6'h01, ST_VLO = 6'h02, ST_RUN = 6'h04,
		ST_WAIT = 6'h08, ST_HALT = 6'h10, ST_STAB = 6'h20
	} crs_state_t;
	typedef struct packed {
		crs_op_t op;
		logic [15:0] data;
	} crs_cmd_t;
	typedef struct packed {
		logic v;
		logic h;
		logic i;
		logic n;
		logic z;
		logic c;
	} crs_flags_t;
endpackage : crs_pkg
`default_nettype wire

// *** test/cpu_register_state_and_flags_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crs_regs.svh"
module cpu_register_state_and_flags_tb_top;
	localparam int STAB = 8;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic cmdValid = 1'b0, vecValid = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, vecHi = 8'h00, vecLo = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic [3:0] irqPend = 4'h0;
	crs_pkg::crs_cmd_t cmd = '0;
	logic [7:0] vecData;
	logic awready, wready, bvalid, arready, rvalid, cmdReady, vecRd, irqReq, coreRun, illegalRst;
	logic [1:0] bresp, rresp, irqSel, rsVal, bsVal;
	logic [31:0] rdata, rdVal;
	logic [15:0] vecAddr, stackAddr;
	logic [7:0] pushData;
	int miscompares = 0;
	int checkCount = 0;

	crs_core #(.STAB_CYC(STAB)) dut (.clk, .reset, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
		.wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.cmdValid, .cmdReady, .cmd, .vecRd, .vecAddr, .vecValid, .vecData, .stackAddr, .pushData,
		.irqPend, .irqReq, .irqSel, .coreRun, .illegalRst);

	// vector memory answers by address
	assign vecData = vecAddr[0] ? vecLo : vecHi;

	// free-running clock
	always #10 clk = ~clk;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checkCount++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic axW(input logic [7:0] a, input logic [31:0] d);
		logic ad = 1'b0;
		logic wd = 1'b0;
		@(posedge clk);
		{awvalid, wvalid, bready} <= 3'b111;
		awaddr <= a;
		wdata <= d;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		bsVal = bresp;
	endtask : axW

	task automatic axR(input logic [7:0] a);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		rdVal = rdata;
		rsVal = rresp;
	endtask : axR

	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		axR(a);
		chk(rdVal, e);
	endtask : rdChk

	// offer one op, hold until taken, then let its effects settle
	task automatic doCmd(input crs_pkg::crs_op_t op, input logic [15:0] d);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmd <= {op, d};
		do @(posedge clk); while (cmdReady !== 1'b1);
		cmdValid <= 1'b0;
		#1;
	endtask : doCmd

	task automatic fetchVec(input logic [7:0] hi, input logic [7:0] lo);
		chk(vecAddr, `CRS_VEC_HI);
		chk(vecRd, 1'b1);
		@(posedge clk);
		vecValid <= 1'b1;
		vecHi <= hi;
		vecLo <= lo;
		for (int i = 0; i < 20 && cmdReady !== 1'b1; i++) @(posedge clk);
		vecValid <= 1'b0;
	endtask : fetchVec

	task automatic tReset();
		fetchVec(8'h12, 8'h34);
		chk(vecRd, 1'b0);
		rdChk(`CRS_PGM_OFS, 32'h1234);
		rdChk(`CRS_STA_OFS, 32'h44);
		rdChk(`CRS_CTL_OFS, 32'h1);
		rdChk(`CRS_STK_OFS, 32'h00FF);
		rdChk(`CRS_FLG_OFS, 32'h68);
		axR(8'h40);
		chk(rsVal, `CRS_RESP_ERR);
		chk(rdVal, 32'h0);
		axW(8'h40, 32'hFFFF_FFFF);
		chk(bsVal, `CRS_RESP_ERR);
		wstrb <= 4'h2;
		axW(`CRS_IDX_OFS, 32'h0000_5577);
		wstrb <= 4'hF;
		chk(bsVal, `CRS_RESP_OK);
		rdChk(`CRS_IDX_OFS, 32'h5500);
		doCmd(crs_pkg::OP_FETCH, 16'h0000);
		rdChk(`CRS_PGM_OFS, 32'h1235);
		doCmd(crs_pkg::OP_JUMP, 16'h4000);
		rdChk(`CRS_PGM_OFS, 32'h4000);
		$display("done: reset and vector");
	endtask : tReset

	task automatic tAlu();
		doCmd(crs_pkg::OP_LOAD_ACC, 16'h007F);
		doCmd(crs_pkg::OP_ADD, 16'h0001);
		rdChk(`CRS_ACC_OFS, 32'h80);
		rdChk(`CRS_FLG_OFS, 32'hFC);
		doCmd(crs_pkg::OP_ADD, 16'h0080);
		rdChk(`CRS_FLG_OFS, 32'hEB);
		doCmd(crs_pkg::OP_AND, 16'h00FF);
		rdChk(`CRS_FLG_OFS, 32'h6B);
		doCmd(crs_pkg::OP_LOAD_ACC, 16'h0009);
		doCmd(crs_pkg::OP_ADC, 16'h0008);
		rdChk(`CRS_FLG_OFS, 32'h78);
		doCmd(crs_pkg::OP_DECIMAL_ADJUST, 16'h0000);
		rdChk(`CRS_ACC_OFS, 32'h18);
		doCmd(crs_pkg::OP_SUB, 16'h0020);
		rdChk(`CRS_FLG_OFS, 32'h7D);
		doCmd(crs_pkg::OP_LOAD_ACC, 16'h0040);
		doCmd(crs_pkg::OP_LSL, 16'h0000);
		rdChk(`CRS_FLG_OFS, 32'hFC);
		$display("done: arithmetic flags");
	endtask : tAlu

	task automatic tStack();
		axW(`CRS_STK_OFS, 32'h1234);
		doCmd(crs_pkg::OP_LOAD_ACC, 16'h005A);
		doCmd(crs_pkg::OP_PUSH, 16'h0000);
		chk(pushData, 8'h5A);
		rdChk(`CRS_STK_OFS, 32'h1233);
		doCmd(crs_pkg::OP_PULL, 16'h0000);
		rdChk(`CRS_STK_OFS, 32'h1234);
		doCmd(crs_pkg::OP_STACK_LOW_RESET, 16'h0000);
		rdChk(`CRS_STK_OFS, 32'h12FF);
		doCmd(crs_pkg::OP_STACK_REL8, 16'h0005);
		chk(stackAddr, 16'h1304);
		doCmd(crs_pkg::OP_STACK_REL16, 16'h0100);
		chk(stackAddr, 16'h13FF);
		doCmd(crs_pkg::OP_LOAD_INDEX, 16'hABCD);
		rdChk(`CRS_IDX_OFS, 32'hABCD);
		doCmd(crs_pkg::OP_PUSH_INDEX_HIGH, 16'h0000);
		chk(pushData, 8'hAB);
		rdChk(`CRS_STK_OFS, 32'h12FE);
		doCmd(crs_pkg::OP_PULL_INDEX_HIGH, 16'h0012);
		rdChk(`CRS_IDX_OFS, 32'h12CD);
		chk(bsVal, `CRS_RESP_OK);
		$display("done: stack pointer");
	endtask : tStack

	task automatic tIrq();
		axW(`CRS_FLG_OFS, 32'h0);
		rdChk(`CRS_FLG_OFS, 32'h68);
		doCmd(crs_pkg::OP_MASK_CLEAR, 16'h0000);
		rdChk(`CRS_FLG_OFS, 32'h60);
		irqPend <= 4'b0110;
		repeat (3) @(posedge clk);
		#1;
		chk(irqReq, 1'b1);
		chk(irqSel, 2'h1);
		doCmd(crs_pkg::OP_INT_ENTER, 16'h2000);
		repeat (2) @(posedge clk);
		#1;
		chk(irqReq, 1'b0);
		rdChk(`CRS_FLG_OFS, 32'h68);
		rdChk(`CRS_PGM_OFS, 32'h2000);
		irqPend <= 4'h0;
		doCmd(crs_pkg::OP_INTERRUPT_RETURN, 16'h0060);
		rdChk(`CRS_FLG_OFS, 32'h60);
		rdChk(`CRS_STK_OFS, 32'h1300);
		$display("done: interrupt mask");
	endtask : tIrq

	task automatic tPower();
		int n = 0;
		doCmd(crs_pkg::OP_INT_ENTER, 16'h3000);
		doCmd(crs_pkg::OP_WAIT, 16'h0000);
		chk(coreRun, 1'b0);
		rdChk(`CRS_FLG_OFS, 32'h60);
		irqPend <= 4'b1000;
		for (int i = 0; i < 10 && coreRun !== 1'b1; i++) @(posedge clk);
		irqPend <= 4'h0;
		chk(coreRun, 1'b1);
		rdChk(`CRS_FLG_OFS, 32'h60);
		doCmd(crs_pkg::OP_INT_ENTER, 16'h3000);
		doCmd(crs_pkg::OP_HALT, 16'h0000);
		chk(coreRun, 1'b0);
		rdChk(`CRS_FLG_OFS, 32'h60);
		irqPend <= 4'b0001;
		while (coreRun !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		irqPend <= 4'h0;
		chk(32'(n >= STAB && n < 100), 32'h1);
		axW(`CRS_CTL_OFS, 32'h0);
		doCmd(crs_pkg::OP_HALT, 16'h0000);
		chk(illegalRst, 1'b1);
		@(posedge clk);
		#1;
		chk(illegalRst, 1'b0);
		fetchVec(8'h56, 8'h78);
		rdChk(`CRS_PGM_OFS, 32'h5678);
		rdChk(`CRS_STK_OFS, 32'h00FF);
		rdChk(`CRS_FLG_OFS, 32'h68);
		$display("done: low power modes");
	endtask : tPower

	task automatic summarize();
		$display("checks %0d, mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	// main sequence after a four-cycle reset
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		tReset();
		tAlu();
		tStack();
		tIrq();
		tPower();
		summarize();
	end

	// cut a hang short
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		$display("watchdog expired");
		summarize();
	end
endmodule : cpu_register_state_and_flags_tb_top
`default_nettype wire
